//--- common/bfs_defs.svh
/*
 * Constants for the buck fault/status supervisor: timing, reset values, address.
 * Assumes a 40 MHz system clock; included by its bare name.
 */
`ifndef BFS_DEFS_SVH
`define BFS_DEFS_SVH

// ********************************
// clock and timing
// ********************************
`define BFS_CLK_MHZ        40
`define BFS_INIT_TIME_US   1000
`define BFS_INIT_CYC       (`BFS_INIT_TIME_US * `BFS_CLK_MHZ)
`define BFS_PON_UNIT_US    500
`define BFS_PON_UNIT_CYC   (`BFS_PON_UNIT_US * `BFS_CLK_MHZ)
`define BFS_SS_UNIT_US     500
`define BFS_SS_UNIT_CYC    (`BFS_SS_UNIT_US * `BFS_CLK_MHZ)
`define BFS_PGD_DIV        10
`define BFS_UV_CYCLES      4'h8
`define BFS_TMR_W          24

// ********************************
// address and reset values
// ********************************
// upper slave-address bits, value arbitrary
`define BFS_ADDR_HI        4'h5
`define BFS_SWEN_RST       1'h0

`endif

//--- common/bfs_pkg.sv
/*
 * Types for the buck fault/status supervisor.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package bfs_pkg;

    typedef struct packed {
        logic       fb_above_120;
        logic       fb_below_110;
        logic       fb_above_90;
        logic       fb_below_80;
        logic       fb_below_70;
        logic       cur_limit;
        logic       ot_rise;
        logic       ot_fall;
        logic       zero_cross;
        logic       pwm_on;
        logic       en_pin;
        logic [2:0] addr_sel;
    } bfs_cmp_t;

    typedef struct packed {
        logic [1:0] pon_delay;
        logic [1:0] ss_time;
        logic [3:0] vout_offset;
        logic [1:0] margin;
        logic [1:0] psave_mode;
        logic [1:0] freq_sel;
    } bfs_cfg_t;

    typedef struct packed {
        logic undervoltage_flag;
        logic overvoltage_flag;
        logic ot;
        logic current_limit_flag;
        logic bo;
        logic did_not_start_flag;
    } bfs_flags_t;

    typedef struct packed {
        logic dcm;
        logic power_good_pin;
    } bfs_status_t;

    typedef enum logic [2:0] {
        BFS_OFF, BFS_INIT, BFS_PON, BFS_SS, BFS_PGD, BFS_RUN, BFS_UVLATCH, BFS_OTHOLD
    } bfs_state_t;

endpackage

//--- hw/bfs_supervisor.sv
/*
 * Fault and status supervisor for a step-down converter controller:
 * flags, status, enable sequencing, gate forcing and power-good.
 * Assumes comparator results and pins arrive asynchronously, host-side
 * bits come from logic on i_sys_clk, and i_nrst is the power-on reset.
 */
`timescale 1ns/1ps
`include "bfs_defs.svh"
`default_nettype none

module bfs_supervisor #(
    parameter int unsigned P_INIT_CYC     = `BFS_INIT_CYC,
    parameter int unsigned P_PON_UNIT_CYC = `BFS_PON_UNIT_CYC,
    parameter int unsigned P_SS_UNIT_CYC  = `BFS_SS_UNIT_CYC
) (
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_nrst,
    input  wire bfs_pkg::bfs_cmp_t    i_cmp,
    input  wire logic                 i_switcher_enable_bit,
    input  wire logic                 i_clear_flags_bit,
    input  wire bfs_pkg::bfs_cfg_t    i_cfg,
    output logic                      o_high_side_gate,
    output logic                      o_low_side_gate,
    output logic                      o_power_good_pin_oe_n,
    output logic                      o_power_good_out,
    output bfs_pkg::bfs_flags_t       o_flags,
    output bfs_pkg::bfs_status_t      o_status,
    output bfs_pkg::bfs_cfg_t         o_cfg,
    output logic                      o_switcher_enable_bit,
    output logic [6:0]                o_i2c_addr
);

    // ********************************
    // state
    // ********************************
    typedef struct packed {
        bfs_pkg::bfs_cmp_t    sync1;
        bfs_pkg::bfs_cmp_t    sync2;
        bfs_pkg::bfs_state_t  state;
        logic [`BFS_TMR_W-1:0] timer;
        logic                 need_init;
        logic                 en_prev;
        logic                 clr_prev;
        logic                 pwm_prev;
        logic                 sw_en;
        bfs_pkg::bfs_cfg_t    cfg;
        bfs_pkg::bfs_flags_t  flags;
        bfs_pkg::bfs_status_t status;
        logic                 ov_hold;
        logic                 uv_low;
        logic                 pg_seen;
        logic                 cyc_cl;
        logic                 cyc_b70;
        logic [3:0]           uv_cnt;
        logic                 hs;
        logic                 ls;
        logic [6:0]           addr;
    } bfs_sup_t;

    bfs_sup_t s_q;
    bfs_sup_t s_d;

    // step count times unit, cut to the timer width
    function automatic logic [`BFS_TMR_W-1:0] step_cycles(input logic [1:0] code,
                                                          input int unsigned unit);
        int unsigned prod;
        prod = (int'(code) + 1) * unit;
        return prod[`BFS_TMR_W-1:0];
    endfunction

    bfs_pkg::bfs_cmp_t   cmp;
    logic                en_req;
    logic                en_fall;
    logic                clr;
    logic                switching;
    logic                cyc_start;
    logic                timer_done;
    bfs_pkg::bfs_flags_t set_f;
    bfs_pkg::bfs_flags_t clr_f;

    // ********************************
    // next state
    // ********************************
    always_comb begin
        s_d = s_q;
        // only the second stage is read by logic
        s_d.sync1 = i_cmp;
        s_d.sync2 = s_q.sync1;
        cmp = s_q.sync2;
        s_d.sw_en = i_switcher_enable_bit;
        s_d.cfg = i_cfg;
        s_d.addr = {`BFS_ADDR_HI, cmp.addr_sel};
        en_req = cmp.en_pin & s_q.sw_en;
        en_fall = s_q.en_prev & ~cmp.en_pin;
        s_d.en_prev = cmp.en_pin;
        // rising edge only, so a held bit clears once
        clr = i_clear_flags_bit & ~s_q.clr_prev;
        s_d.clr_prev = i_clear_flags_bit;
        cyc_start = cmp.pwm_on & ~s_q.pwm_prev;
        s_d.pwm_prev = cmp.pwm_on;
        timer_done = (s_q.timer == '0);
        if (!timer_done) begin
            s_d.timer = s_q.timer - 1'b1;
        end
        set_f = '0;
        switching = (s_q.state == bfs_pkg::BFS_SS) || (s_q.state == bfs_pkg::BFS_PGD) ||
                    (s_q.state == bfs_pkg::BFS_RUN);
        // ov window: set above 120%, released below 110%
        if (cmp.fb_above_120) begin
            s_d.ov_hold = 1'b1;
        end else if (cmp.fb_below_110) begin
            s_d.ov_hold = 1'b0;
        end
        // every start begins in the low window, so power-good waits for 90%
        if (cmp.fb_below_80 || !switching) begin
            s_d.uv_low = 1'h1;
        end else if (cmp.fb_above_90) begin
            s_d.uv_low = 1'b0;
        end

        if (cmp.en_pin == 1'b0) begin
            s_d.need_init = 1'b1;
        end

        // ********************************
        // sequencer
        // ********************************
        if (!en_req) begin
            s_d.state = bfs_pkg::BFS_OFF;
        end else if (cmp.ot_rise && s_q.state != bfs_pkg::BFS_OTHOLD) begin
            s_d.state = bfs_pkg::BFS_OTHOLD;
            set_f.ot = 1'b1;
        end else begin
            unique case (s_q.state)
                bfs_pkg::BFS_OFF: begin
                    if (s_q.need_init) begin
                        s_d.state = bfs_pkg::BFS_INIT;
                        s_d.timer = P_INIT_CYC[`BFS_TMR_W-1:0];
                        s_d.need_init = 1'b0;
                    end else begin
                        s_d.state = bfs_pkg::BFS_PON;
                        s_d.timer = step_cycles(s_q.cfg.pon_delay, P_PON_UNIT_CYC);
                    end
                end
                bfs_pkg::BFS_INIT: begin
                    if (timer_done) begin
                        s_d.state = bfs_pkg::BFS_PON;
                        s_d.timer = step_cycles(s_q.cfg.pon_delay, P_PON_UNIT_CYC);
                    end
                end
                bfs_pkg::BFS_PON: begin
                    if (timer_done) begin
                        s_d.state = bfs_pkg::BFS_SS;
                        s_d.timer = step_cycles(s_q.cfg.ss_time, P_SS_UNIT_CYC);
                    end
                end
                bfs_pkg::BFS_SS: begin
                    if (timer_done) begin
                        s_d.state = bfs_pkg::BFS_PGD;
                        s_d.timer = step_cycles(s_q.cfg.ss_time,
                                                P_SS_UNIT_CYC / `BFS_PGD_DIV);
                    end
                end
                bfs_pkg::BFS_PGD: begin
                    if (timer_done) begin
                        s_d.state = bfs_pkg::BFS_RUN;
                        set_f.did_not_start_flag = ~cmp.fb_above_90;
                    end
                end
                bfs_pkg::BFS_RUN: begin
                    if (s_q.uv_cnt == `BFS_UV_CYCLES) begin
                        s_d.state = bfs_pkg::BFS_UVLATCH;
                        set_f.undervoltage_flag = 1'b1;
                    end
                end
                // left by dropping the enable pin or bit, or by an overtemperature rise
                bfs_pkg::BFS_UVLATCH: begin
                    s_d.state = bfs_pkg::BFS_UVLATCH;
                end
                bfs_pkg::BFS_OTHOLD: begin
                    if (cmp.ot_fall) begin
                        s_d.state = bfs_pkg::BFS_PON;
                        s_d.timer = step_cycles(s_q.cfg.pon_delay, P_PON_UNIT_CYC);
                    end
                end
            endcase
        end

        // ********************************
        // gates and power-good
        // ********************************
        s_d.hs = switching & cmp.pwm_on & ~cmp.cur_limit & ~s_q.ov_hold;
        // soft-start lets zero current turn the low side off for pre-bias
        s_d.ls = switching & ((~cmp.pwm_on &
                 ~(s_q.state == bfs_pkg::BFS_SS && cmp.zero_cross)) | s_q.ov_hold);
        s_d.status.power_good_pin = (s_q.state == bfs_pkg::BFS_RUN) &
                           ~s_q.uv_low & ~s_q.ov_hold;
        s_d.status.dcm = switching & cmp.zero_cross;
        if (s_q.status.power_good_pin) begin
            s_d.pg_seen = 1'b1;
        end else if (!switching) begin
            s_d.pg_seen = 1'b0;
        end
        // ********************************
        // undervoltage cycle counter
        // ********************************
        if (!s_q.pg_seen || s_q.state != bfs_pkg::BFS_RUN) begin
            s_d.uv_cnt = '0;
        end else if (cyc_start) begin
            if (s_q.cyc_cl && s_q.cyc_b70) begin
                s_d.uv_cnt = s_q.uv_cnt + 4'h1;
            end else begin
                s_d.uv_cnt = '0;
            end
            s_d.cyc_cl = cmp.cur_limit;
            s_d.cyc_b70 = cmp.fb_below_70;
        end else begin
            s_d.cyc_cl = s_q.cyc_cl | cmp.cur_limit;
            s_d.cyc_b70 = s_q.cyc_b70 & cmp.fb_below_70;
        end
        // ********************************
        // flags
        // ********************************
        set_f.overvoltage_flag = cmp.fb_above_120;
        set_f.current_limit_flag = switching & cmp.cur_limit;
        set_f.bo = s_q.pg_seen & cmp.fb_below_80 & ~cmp.cur_limit;
        clr_f = (clr || en_fall) ? '1 : '0;
        if (cmp.fb_above_120 && !en_fall) begin
            clr_f.overvoltage_flag = 1'b0;
        end
        // a set in the clearing cycle wins
        s_d.flags = (s_q.flags & ~clr_f) | set_f;
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_q <= '0;
            s_q.state <= bfs_pkg::BFS_OFF;
            s_q.need_init <= 1'b1;
            s_q.uv_low <= 1'b1;
            s_q.sw_en <= `BFS_SWEN_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_high_side_gate      = s_q.hs;
    assign o_low_side_gate       = s_q.ls;
    assign o_power_good_pin_oe_n = s_q.status.power_good_pin;
    assign o_power_good_out      = s_q.status.power_good_pin;
    assign o_flags               = s_q.flags;
    assign o_status              = s_q.status;
    assign o_cfg                 = s_q.cfg;
    assign o_switcher_enable_bit = s_q.sw_en;
    assign o_i2c_addr            = s_q.addr;

    // ********************************
    // assertions
    // ********************************
    property p_ov_hs_off;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        s_q.ov_hold |=> !o_high_side_gate;
    endproperty
    a_ov_hs_off: assert property (p_ov_hs_off) else $error("high side on in overvoltage");
    property p_cl_inhibit;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        cmp.cur_limit |=> !o_high_side_gate;
    endproperty
    a_cl_inhibit: assert property (p_cl_inhibit) else $error("high side on in limit");
    property p_ot_gates;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        s_q.state == bfs_pkg::BFS_OTHOLD && !clr && !en_fall |=>
            !o_high_side_gate && !o_low_side_gate && o_flags.ot;
    endproperty
    a_ot_gates: assert property (p_ot_gates) else $error("gates on in overtemp");
    property p_uv_latch;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        $rose(s_q.state == bfs_pkg::BFS_UVLATCH) |->
            o_flags.undervoltage_flag ##1 (!o_high_side_gate && !o_low_side_gate);
    endproperty
    a_uv_latch: assert property (p_uv_latch) else $error("undervoltage latch wrong");
    property p_pg_ov;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        s_q.ov_hold |=> !o_power_good_out;
    endproperty
    a_pg_ov: assert property (p_pg_ov) else $error("power good high in overvoltage");
    property p_pg_uv;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        s_q.uv_low |=> !o_power_good_out;
    endproperty
    a_pg_uv: assert property (p_pg_uv) else $error("power good high while low");
    property p_pg_startup;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        s_q.state != bfs_pkg::BFS_RUN |=> !o_power_good_out;
    endproperty
    a_pg_startup: assert property (p_pg_startup) else $error("power good before run");
    property p_ovo_kept;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        clr && cmp.fb_above_120 |=> o_flags.overvoltage_flag;
    endproperty
    a_ovo_kept: assert property (p_ovo_kept) else $error("overvoltage flag cleared early");
    property p_flag_sticky;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        o_flags.current_limit_flag && !clr && !en_fall |=> o_flags.current_limit_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped by itself");
    property p_en_off;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        !cmp.en_pin |=> ##1 (!o_high_side_gate && !o_low_side_gate);
    endproperty
    a_en_off: assert property (p_en_off) else $error("gates on with enable low");

endmodule // bfs_supervisor

`default_nettype wire

//--- tb/bfs_host_model.sv
/*
 * Host-side partner: drives switcher enable, clear-flags and settings.
 * Assumes the bench raises requests; outputs change after falling edges.
 */
`timescale 1ns/1ps
`default_nettype none

module bfs_host_model (
    input  wire logic              i_sys_clk,
    input  wire logic              i_nrst,
    input  wire logic              i_swen_req,
    input  wire logic              i_clr_req,
    input  wire bfs_pkg::bfs_cfg_t i_cfg_req,
    output logic                   o_switcher_enable_bit,
    output logic                   o_clear_flags_bit,
    output bfs_pkg::bfs_cfg_t      o_cfg
);
    logic clr_req_q;

    // falling edge so the design samples settled levels
    always_ff @(negedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_switcher_enable_bit <= 1'h0;
            o_clear_flags_bit     <= 1'h0;
            o_cfg                 <= '0;
            clr_req_q             <= 1'h0;
        end else begin
            o_switcher_enable_bit <= i_swen_req;
            o_cfg                 <= i_cfg_req;
            clr_req_q             <= i_clr_req;
            // one write per request, never left high
            o_clear_flags_bit     <= i_clr_req & ~clr_req_q;
        end
    end
endmodule // bfs_host_model

`default_nettype wire

//--- tb/bfs_supervisor_bench.sv
/*
 * Self-checking bench for the buck fault/status supervisor.
 * Assumes shortened start-up counts; the host model drives the host bits.
 */
`timescale 1ns/1ps
`include "bfs_defs.svh"
`default_nettype none

module bfs_supervisor_bench;
    logic                 clk = 1'h0;
    logic                 nrst = 1'h0;
    logic                 swen_req = 1'h0;
    logic                 clr_req = 1'h0;
    logic                 pwm_run = 1'h0;
    logic                 pwm_clk = 1'h0;
    bfs_pkg::bfs_cmp_t    cmp;
    bfs_pkg::bfs_cmp_t    cmp_pin;
    bfs_pkg::bfs_cfg_t    cfg_req;
    bfs_pkg::bfs_cfg_t    cfg;
    bfs_pkg::bfs_cfg_t    cfg_rb;
    bfs_pkg::bfs_flags_t  flags;
    bfs_pkg::bfs_status_t status;
    logic                 swen;
    logic                 clr;
    logic                 hsg;
    logic                 lsg;
    logic                 pg_oe_n;
    logic                 pg;
    logic                 swen_rb;
    logic [6:0]           addr;
    int                   errors = 0;
    int                   comparisons = 0;
    int                   cycles = 0;

    // ********************************
    // clock, switching-cycle clock, timeout
    // ********************************
    always #12.5 clk = ~clk;

    // switching-cycle clock stands still, low, outside its bursts
    initial begin
        #7;
        forever #100 pwm_clk <= pwm_run & ~pwm_clk;
    end

    // one driver per variable: the burst clock joins the task-driven level here
    always_comb begin
        cmp_pin = cmp;
        cmp_pin.pwm_on = cmp.pwm_on | pwm_clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("BAD %0t timeout", $time);
            stop_test();
        end
    end

    bfs_host_model host (
        .i_sys_clk(clk), .i_nrst(nrst), .i_swen_req(swen_req), .i_clr_req(clr_req),
        .i_cfg_req(cfg_req), .o_switcher_enable_bit(swen), .o_clear_flags_bit(clr),
        .o_cfg(cfg)
    );

    bfs_supervisor #(.P_INIT_CYC(20), .P_PON_UNIT_CYC(10), .P_SS_UNIT_CYC(40)) dut (
        .i_sys_clk(clk), .i_nrst(nrst), .i_cmp(cmp_pin), .i_switcher_enable_bit(swen),
        .i_clear_flags_bit(clr), .i_cfg(cfg), .o_high_side_gate(hsg),
        .o_low_side_gate(lsg), .o_power_good_pin_oe_n(pg_oe_n), .o_power_good_out(pg),
        .o_flags(flags), .o_status(status), .o_cfg(cfg_rb),
        .o_switcher_enable_bit(swen_rb), .o_i2c_addr(addr)
    );

    // ********************************
    // helpers
    // ********************************
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'h1) begin
            errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wait_pg(input int lim);
        for (int n = 0; n < lim && pg !== 1'h1; n++) @(negedge clk);
        chk(pg === 1'h1 && pg_oe_n === 1'h1 && status.power_good_pin === 1'h1, "no power good");
    endtask

    task automatic clear_flags;
        clr_req <= 1'h1;
        tick(3);
        clr_req <= 1'h0;
        tick(4);
    endtask

    task automatic fb_ok;
        cmp.fb_above_120 <= 1'h0;
        cmp.fb_below_110 <= 1'h1;
        cmp.fb_above_90  <= 1'h1;
        cmp.fb_below_80  <= 1'h0;
        cmp.fb_below_70  <= 1'h0;
    endtask

    task automatic stop_test;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ********************************
    // scenarios
    // ********************************
    task automatic t_reset;
        chk(hsg === 1'h0 && lsg === 1'h0 && pg_oe_n === 1'h0 && flags === '0, "reset");
        nrst <= 1'h1;
        tick(5);
        chk(addr === {`BFS_ADDR_HI, 3'h6}, "address");
        cmp.addr_sel <= 3'h1;
        tick(5);
        chk(addr === {`BFS_ADDR_HI, 3'h1}, "address");
        $display("test reset done");
    endtask

    task automatic t_start;
        cfg_req <= 14'h02d6;
        fb_ok();
        swen_req <= 1'h1;
        cmp.en_pin <= 1'h1;
        tick(50);
        chk(pg === 1'h0 && pg_oe_n === 1'h0, "power good in soft-start");
        wait_pg(150);
        chk(cfg_rb === 14'h02d6 && swen_rb === 1'h1, "readback");
        chk(flags === '0, "flag at start");
        $display("test start done");
    endtask

    task automatic t_current_limit_flag;
        cmp.pwm_on <= 1'h1;
        cmp.cur_limit <= 1'h1;
        tick(6);
        chk(hsg === 1'h0 && flags.current_limit_flag === 1'h1, "current limit");
        cmp.cur_limit <= 1'h0;
        tick(6);
        chk(hsg === 1'h1, "high side not resumed");
        cmp.pwm_on <= 1'h0;
        cmp.zero_cross <= 1'h1;
        tick(6);
        chk(status.dcm === 1'h1, "dcm status");
        cmp.zero_cross <= 1'h0;
        tick(6);
        chk(status.dcm === 1'h0 && flags.current_limit_flag === 1'h1, "status or flag");
        clear_flags();
        chk(flags === '0, "clear");
        $display("test current limit done");
    endtask

    task automatic t_ov;
        cmp.fb_above_120 <= 1'h1;
        cmp.fb_below_110 <= 1'h0;
        tick(6);
        chk(lsg === 1'h1 && hsg === 1'h0 && flags.overvoltage_flag === 1'h1 && pg_oe_n === 1'h0, "ov");
        clear_flags();
        chk(flags.overvoltage_flag === 1'h1, "ov flag cleared while high");
        cmp.fb_above_120 <= 1'h0;
        tick(6);
        chk(pg === 1'h0 && flags.overvoltage_flag === 1'h1, "pg above 110");
        cmp.fb_below_110 <= 1'h1;
        wait_pg(10);
        clear_flags();
        chk(flags === '0, "ov flag kept");
        $display("test overvoltage done");
    endtask

    task automatic t_bo;
        cmp.fb_below_80 <= 1'h1;
        cmp.fb_above_90 <= 1'h0;
        tick(6);
        chk(flags.bo === 1'h1 && pg === 1'h0 && flags.undervoltage_flag === 1'h0, "brownout");
        cmp.fb_below_80 <= 1'h0;
        tick(6);
        chk(pg === 1'h0, "pg under 90");
        cmp.fb_above_90 <= 1'h1;
        wait_pg(10);
        clear_flags();
        $display("test brownout done");
    endtask

    task automatic t_uv;
        cmp.cur_limit <= 1'h1;
        cmp.fb_below_80 <= 1'h1;
        cmp.fb_below_70 <= 1'h1;
        cmp.fb_above_90 <= 1'h0;
        pwm_run <= 1'h1;
        tick(40);
        chk(flags.undervoltage_flag === 1'h0 && flags.bo === 1'h0, "uv early or bo");
        tick(80);
        chk(flags.undervoltage_flag === 1'h1 && hsg === 1'h0 && lsg === 1'h0, "uv latch");
        pwm_run <= 1'h0;
        cmp.pwm_on <= 1'h0;
        cmp.cur_limit <= 1'h0;
        fb_ok();
        tick(30);
        chk(hsg === 1'h0 && lsg === 1'h0 && pg === 1'h0, "left latch");
        swen_req <= 1'h0;
        tick(8);
        chk(flags.undervoltage_flag === 1'h1 && hsg === 1'h0, "enable bit off");
        swen_req <= 1'h1;
        wait_pg(150);
        clear_flags();
        $display("test undervoltage done");
    endtask

    task automatic t_ot;
        cfg_req <= 14'h16d6;
        cmp.ot_rise <= 1'h1;
        tick(6);
        chk(flags.ot === 1'h1 && hsg === 1'h0 && lsg === 1'h0 && pg === 1'h0, "ot");
        cmp.ot_rise <= 1'h0;
        cmp.ot_fall <= 1'h1;
        tick(6);
        cmp.ot_fall <= 1'h0;
        chk(pg === 1'h0, "pg in restart");
        chk(cfg_rb === 14'h16d6, "readback");
        // longer codes: 21 + 81 cycles before the good delay even starts
        tick(90);
        chk(pg === 1'h0 && pg_oe_n === 1'h0, "pg before longer soft-start");
        wait_pg(150);
        $display("test overtemperature done");
    endtask

    task automatic t_dns;
        cmp.en_pin <= 1'h0;
        tick(6);
        chk(flags === '0 && hsg === 1'h0 && lsg === 1'h0 && pg === 1'h0, "pin off");
        cmp.fb_above_90 <= 1'h0;
        cmp.en_pin <= 1'h1;
        // init, then the longer codes left by the overtemperature test
        tick(145);
        chk(flags.did_not_start_flag === 1'h1 && pg === 1'h0, "did not start");
        cmp.fb_above_90 <= 1'h1;
        wait_pg(20);
        $display("test did not start done");
    endtask

    initial begin
        cmp = '0;
        cmp.addr_sel = 3'h6;
        cfg_req = '0;
        tick(20);
        t_reset();
        t_start();
        t_current_limit_flag();
        t_ov();
        t_bo();
        t_uv();
        t_ot();
        t_dns();
        stop_test();
    end
endmodule // bfs_supervisor_bench

`default_nettype wire
